// >>> logic/dwe_dma.sv
/*
  Multi-channel DMA: AHB register slave, AHB master engine moving one item
  per request with width conversion, error handling and event flags.
  Assumes word-only register access and peripherals that drop their
  request in the cycle after the acknowledge pulse.
*/
// What this block does
// - 16 to 32: zero-extend, advance 2/4
// - 32 to 8: low byte, advance 4/1
// - 32 to 16: low halfword, advance 4/2
// - 32 to 32: unchanged, both advance 4
// - Narrow writes replicate data on lanes
// - Halfword twice, byte four times
// - Reserved region access is transfer error
// - Transfer error clears channel enable
// - Error sets flag, interrupt if enabled
// - Three events, own flags and enables
// - Peripheral requests muxed with converter request
// - Per-channel bit picks request source
// - Registers relative to fixed base
// - Status at zero, read-only, resets zero
// - Flag clear at four, write-only
// - Hardware sets flags, writing one clears
// - Per-channel any-event flag, four bits
// - Half flag after half the items
`timescale 1ns/1ps
`include "dwe_cfg.svh"

module dwe_dma (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      s_hsel_i,
  input  wire logic [31:0]               s_haddr_i,
  input  wire logic [1:0]                s_htrans_i,
  input  wire logic                      s_hwrite_i,
  input  wire logic [2:0]                s_hsize_i,
  input  wire logic [31:0]               s_hwdata_i,
  input  wire logic                      s_hready_i,
  output logic      [31:0]               s_hrdata_o,
  output logic                           s_hready_o,
  output logic                           s_hresp_o,
  output dwe_pkg::dwe_ahb_m_s            m_ahb_o,
  input  wire logic [31:0]               m_hrdata_i,
  input  wire logic                      m_hready_i,
  input  wire logic                      m_hresp_i,
  input  wire logic [`DWE_NUM_CH-1:0]    periph_req_i,
  input  wire logic                      adc_req_i,
  output logic      [`DWE_NUM_CH-1:0]    req_ack_o,
  output logic                           irq_o
);
  import dwe_pkg::*;

  localparam int          NCH     = `DWE_NUM_CH;
  localparam logic [11:0] CH_BASE = `DWE_OFS_CH_BASE;
  localparam logic [31:0] BASE    = `DWE_BASE_ADDR;

  dwe_ch_cfg_s      cfg_ff  [NCH];
  logic [15:0]      cnt_ff  [NCH];
  logic [15:0]      init_ff [NCH];
  logic [31:0]      src_ff  [NCH];
  logic [31:0]      dst_ff  [NCH];
  logic [31:0]      status_ff;
  logic [31:0]      ie_mask;
  logic [31:0]      set_mask;
  logic [31:0]      clr_mask;
  logic [31:0]      rd_val;
  logic [31:0]      s_hrdata_ff;
  logic [31:0]      wdata_ff;
  logic [31:0]      lane_wdata;
  logic [11:0]      wr_ofs_ff;
  logic [NCH-1:0]   trig;
  logic [NCH-1:0]   en_vec;
  logic [NCH-1:0]   ack_ff;
  logic [2:0]       pick;
  logic [2:0]       cur_ff;
  logic [2:0]       err_ch;
  dwe_state_e       state_ff;
  dwe_ahb_m_s       m_ff;
  logic             s_acc;
  logic             s_bad;
  logic             in_win;
  logic             wr_pend_ff;
  logic             err1_ff;
  logic             s_hready_ff;
  logic             s_hresp_ff;
  logic             wr_fclr;
  logic             wr_ch;
  logic             start;
  logic             ev_done;
  logic             ev_err;
  logic             irq_ff;

  function automatic logic [31:0] sz_bytes(input logic [1:0] sz);
    unique case (sz)
      `DWE_SZ_BYTE: sz_bytes = 32'h0000_0001;
      `DWE_SZ_HALF: sz_bytes = 32'h0000_0002;
      default:      sz_bytes = 32'h0000_0004;
    endcase
  endfunction

  function automatic logic [2:0] to_hsize(input logic [1:0] sz);
    to_hsize = {1'b0, (sz == 2'h3) ? `DWE_SZ_WORD : sz};
  endfunction

  function automatic logic rsvd(input logic [31:0] a);
    rsvd = (a >= `DWE_RSVD_LO) && (a <= `DWE_RSVD_HI);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Register slave

  assign s_acc  = s_hsel_i & s_htrans_i[1] & s_hready_i;
  assign in_win = (s_haddr_i[31:12] == BASE[31:12]);
  assign s_bad  = s_acc & (s_hsize_i != `DWE_HSIZE_WORD);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      wr_ofs_ff  <= 12'h000;
    end else begin
      wr_pend_ff <= s_acc & s_hwrite_i & ~s_bad & in_win;
      wr_ofs_ff  <= s_haddr_i[11:0];
    end
  end

  // Narrow access gets a two-cycle error response
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      err1_ff     <= 1'b0;
      s_hready_ff <= 1'b1;
      s_hresp_ff  <= 1'b0;
    end else if (s_bad && !err1_ff) begin
      err1_ff     <= 1'b1;
      s_hready_ff <= 1'b0;
      s_hresp_ff  <= 1'b1;
    end else if (err1_ff) begin
      err1_ff     <= 1'b0;
      s_hready_ff <= 1'b1;
      s_hresp_ff  <= 1'b1;
    end else begin
      s_hready_ff <= 1'b1;
      s_hresp_ff  <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_haddr_i[11:0] == `DWE_OFS_STATUS) begin
      rd_val = status_ff;
    end else if (s_haddr_i[11:7] == CH_BASE[11:7]) begin
      unique case (s_haddr_i[3:2])
        `DWE_CH_CFG: rd_val = {23'h00_0000, cfg_ff[s_haddr_i[6:4]]};
        `DWE_CH_CNT: rd_val = {16'h0000, cnt_ff[s_haddr_i[6:4]]};
        `DWE_CH_SRC: rd_val = src_ff[s_haddr_i[6:4]];
        `DWE_CH_DST: rd_val = dst_ff[s_haddr_i[6:4]];
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_hrdata_ff <= 32'h0000_0000;
    end else if (s_acc && !s_hwrite_i && !s_bad && in_win) begin
      s_hrdata_ff <= rd_val;
    end else begin
      s_hrdata_ff <= 32'h0000_0000;
    end
  end

  assign wr_fclr = wr_pend_ff && (wr_ofs_ff == `DWE_OFS_FCLR);
  assign wr_ch   = wr_pend_ff && (wr_ofs_ff[11:7] == CH_BASE[11:7]);

  //////////////////////////////////////////////////////////////////////////
  // Request selection

  always_comb begin
    pick = 3'h0;
    trig = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      trig[c] = cfg_ff[c].en && (cnt_ff[c] != 16'h0000) && !ack_ff[c] &&
                (cfg_ff[c].sel_adc ? adc_req_i : periph_req_i[c]);
      if (trig[c]) begin
        pick = 3'(c);
      end
    end
  end

  assign start   = (state_ff == ST_IDLE) && (|trig);
  assign ev_done = (state_ff == ST_WDATA) && !m_hresp_i && m_hready_i;
  assign err_ch  = (state_ff == ST_IDLE) ? pick : cur_ff;

  always_comb begin
    ev_err = 1'b0;
    unique case (state_ff)
      ST_IDLE:  ev_err = start && rsvd(src_ff[pick]);
      ST_RDATA: ev_err = m_hresp_i ||
                         (m_hready_i && rsvd(dst_ff[cur_ff]));
      ST_WDATA: ev_err = m_hresp_i;
      default:  ev_err = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Master engine

  dwe_lane_pack u_lane (
    .src_size_i (cfg_ff[cur_ff].src_size),
    .dst_size_i (cfg_ff[cur_ff].dst_size),
    .src_lo_i   (src_ff[cur_ff][1:0]),
    .rdata_i    (m_hrdata_i),
    .wdata_o    (lane_wdata)
  );

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      cur_ff   <= 3'h0;
      m_ff     <= '0;
      wdata_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (start) begin
            cur_ff <= pick;
            if (!rsvd(src_ff[pick])) begin
              m_ff.haddr  <= src_ff[pick];
              m_ff.htrans <= `DWE_HTRANS_NSEQ;
              m_ff.hwrite <= 1'b0;
              m_ff.hsize  <= to_hsize(cfg_ff[pick].src_size);
              state_ff    <= ST_RADDR;
            end
          end
        end
        ST_RADDR: begin
          if (m_hready_i) begin
            m_ff.htrans <= `DWE_HTRANS_IDLE;
            state_ff    <= ST_RDATA;
          end
        end
        ST_RDATA: begin
          if (m_hresp_i) begin
            state_ff <= ST_IDLE;
          end else if (m_hready_i) begin
            wdata_ff <= lane_wdata;
            if (rsvd(dst_ff[cur_ff])) begin
              state_ff <= ST_IDLE;
            end else begin
              m_ff.haddr  <= dst_ff[cur_ff];
              m_ff.htrans <= `DWE_HTRANS_NSEQ;
              m_ff.hwrite <= 1'b1;
              m_ff.hsize  <= to_hsize(cfg_ff[cur_ff].dst_size);
              state_ff    <= ST_WADDR;
            end
          end
        end
        ST_WADDR: begin
          if (m_hready_i) begin
            m_ff.htrans <= `DWE_HTRANS_IDLE;
            m_ff.hwdata <= wdata_ff;
            state_ff    <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (m_hresp_i || m_hready_i) begin
            m_ff.hwrite <= 1'b0;
            state_ff    <= ST_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Channel registers

  always_ff @(posedge sys_clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        cnt_ff[c]  <= 16'h0000;
        init_ff[c] <= 16'h0000;
        src_ff[c]  <= 32'h0000_0000;
        dst_ff[c]  <= 32'h0000_0000;
      end else begin
        if (ev_done && (cur_ff == 3'(c))) begin
          cnt_ff[c] <= cnt_ff[c] - 16'h0001;
          src_ff[c] <= src_ff[c] + sz_bytes(cfg_ff[c].src_size);
          dst_ff[c] <= dst_ff[c] + sz_bytes(cfg_ff[c].dst_size);
        end
        if (wr_ch && (wr_ofs_ff[6:4] == 3'(c))) begin
          unique case (wr_ofs_ff[3:2])
            `DWE_CH_CNT: begin
              cnt_ff[c]  <= s_hwdata_i[15:0];
              init_ff[c] <= s_hwdata_i[15:0];
            end
            `DWE_CH_SRC: src_ff[c] <= s_hwdata_i;
            `DWE_CH_DST: dst_ff[c] <= s_hwdata_i;
            default: ;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        cfg_ff[c] <= `DWE_CFG_RST;
      end else begin
        if (wr_ch && (wr_ofs_ff[6:4] == 3'(c)) &&
            (wr_ofs_ff[3:2] == `DWE_CH_CFG)) begin
          cfg_ff[c] <= s_hwdata_i[8:0];
        end
        if (ev_err && (err_ch == 3'(c))) begin
          cfg_ff[c].en <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    for (int c = 0; c < NCH; c++) begin
      if (rst_i) begin
        ack_ff[c] <= 1'b0;
      end else begin
        ack_ff[c] <= ev_done && (cur_ff == 3'(c));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags and interrupt

  always_comb begin
    set_mask = 32'h0000_0000;
    if (ev_done) begin
      set_mask[{cur_ff, `DWE_BIT_ANY}] = 1'b1;
      if (cnt_ff[cur_ff] == 16'h0001) begin
        set_mask[{cur_ff, `DWE_BIT_TC}] = 1'b1;
      end
      if ((cnt_ff[cur_ff] - 16'h0001) == (init_ff[cur_ff] >> 1)) begin
        set_mask[{cur_ff, `DWE_BIT_HT}] = 1'b1;
      end
    end
    if (ev_err) begin
      set_mask[{err_ch, `DWE_BIT_ANY}] = 1'b1;
      set_mask[{err_ch, `DWE_BIT_TE}]  = 1'b1;
    end
  end

  assign clr_mask = wr_fclr ? s_hwdata_i : 32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_ff <= `DWE_STATUS_RST;
    end else begin
      status_ff <= (status_ff & ~clr_mask) | set_mask;
    end
  end

  always_comb begin
    ie_mask = 32'h0000_0000;
    for (int c = 0; c < NCH; c++) begin
      en_vec[c]                    = cfg_ff[c].en;
      ie_mask[{3'(c), `DWE_BIT_TC}] = cfg_ff[c].tc_ie;
      ie_mask[{3'(c), `DWE_BIT_HT}] = cfg_ff[c].ht_ie;
      ie_mask[{3'(c), `DWE_BIT_TE}] = cfg_ff[c].te_ie;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(status_ff & ie_mask);
    end
  end

  assign s_hrdata_o = s_hrdata_ff;
  assign s_hready_o = s_hready_ff;
  assign s_hresp_o  = s_hresp_ff;
  assign m_ahb_o    = m_ff;
  assign req_ack_o  = ack_ff;
  assign irq_o      = irq_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  err_disable_a: assert property (
    ev_err |=> !en_vec[$past(err_ch)])
    else $error("channel still enabled after error");
  err_flag_a: assert property (
    ev_err |=> status_ff[{$past(err_ch), `DWE_BIT_TE}])
    else $error("error flag not set");
  any_flag_a: assert property (
    (ev_done || ev_err) |=> status_ff[{$past(err_ch), `DWE_BIT_ANY}])
    else $error("any-event flag not set");
  tc_flag_a: assert property (
    (ev_done && cnt_ff[cur_ff] == 16'h0001) |=>
      status_ff[{$past(cur_ff), `DWE_BIT_TC}] && cnt_ff[$past(cur_ff)] == 0)
    else $error("complete flag or count wrong");
  ht_flag_a: assert property (
    (ev_done && (cnt_ff[cur_ff] - 16'h0001) == (init_ff[cur_ff] >> 1))
      |=> status_ff[{$past(cur_ff), `DWE_BIT_HT}])
    else $error("half flag not set");
  clear_keep_a: assert property (
    (wr_fclr && set_mask == 0) |=>
      status_ff == ($past(status_ff) & ~$past(s_hwdata_i)))
    else $error("flag clear wrong");
  hw_set_a: assert property (
    (set_mask == 0) |=> (status_ff & ~$past(status_ff)) == 0)
    else $error("flag set without event");
  irq_level_a: assert property (
    (|(status_ff & ie_mask)) [*2] |-> irq_o)
    else $error("interrupt missing");
  dst_step_a: assert property (
    ev_done |=> dst_ff[$past(cur_ff)] == $past(dst_ff[cur_ff]) +
      sz_bytes($past(cfg_ff[cur_ff].dst_size)))
    else $error("destination step wrong");
  byte_repl_a: assert property (
    (state_ff == ST_WDATA && m_ff.hsize == 3'h0) |->
      m_ff.hwdata == {4{m_ff.hwdata[7:0]}})
    else $error("byte not replicated");
  half_repl_a: assert property (
    (state_ff == ST_WDATA && m_ff.hsize == 3'h1) |->
      m_ff.hwdata == {2{m_ff.hwdata[15:0]}})
    else $error("halfword not replicated");
  rsvd_err_a: assert property (
    (start && rsvd(src_ff[pick])) |=>
      state_ff == ST_IDLE && m_ff.htrans == `DWE_HTRANS_IDLE)
    else $error("reserved source was issued");

  done_c: cover property (ev_done ##1 status_ff[{$past(cur_ff), 2'h1}]);
  err_c:  cover property (state_ff == ST_WDATA && m_hresp_i);
  adc_c:  cover property (start && cfg_ff[pick].sel_adc);
  irq_c:  cover property (irq_o ##1 wr_fclr);

endmodule

// >>> logic/dwe_lane_pack.sv
/*
  Turns one source read beat into the destination write word.
  Assumes read data arrives on the lanes given by the source address.
*/
`timescale 1ns/1ps
`include "dwe_cfg.svh"

module dwe_lane_pack (
  input  wire logic [1:0]  src_size_i,
  input  wire logic [1:0]  dst_size_i,
  input  wire logic [1:0]  src_lo_i,
  input  wire logic [31:0] rdata_i,
  output logic      [31:0] wdata_o
);

  logic [31:0] shifted;
  logic [31:0] item;

  always_comb begin
    shifted = rdata_i >> {src_lo_i, 3'b000};
    // Zero-extend the source item
    unique case (src_size_i)
      `DWE_SZ_BYTE: item = {24'h00_0000, shifted[7:0]};
      `DWE_SZ_HALF: item = {16'h0000, src_lo_i[1] ? rdata_i[31:16]
                                                : rdata_i[15:0]};
      default:      item = rdata_i;
    endcase
    unique case (dst_size_i)
      `DWE_SZ_BYTE: wdata_o = {4{item[7:0]}};
      `DWE_SZ_HALF: wdata_o = {2{item[15:0]}};
      default:      wdata_o = item;
    endcase
  end

endmodule

// >>> shared/dwe_cfg.svh
/*
  Offsets, field positions, reset values and encodings of the DMA block.
  Assumes it is included by bare name from files that need these values.
*/
`ifndef DWE_CFG_SVH
`define DWE_CFG_SVH

`define DWE_NUM_CH       8
`define DWE_BASE_ADDR    32'hA000_0000
`define DWE_OFS_STATUS   12'h000
`define DWE_OFS_FCLR     12'h004
`define DWE_OFS_CH_BASE  12'h100
`define DWE_CH_CFG       2'h0
`define DWE_CH_CNT       2'h1
`define DWE_CH_SRC       2'h2
`define DWE_CH_DST       2'h3
`define DWE_STATUS_RST   32'h0000_0000
`define DWE_CFG_RST      9'h000
`define DWE_BIT_ANY      2'h0
`define DWE_BIT_TC       2'h1
`define DWE_BIT_HT       2'h2
`define DWE_BIT_TE       2'h3
`define DWE_SZ_BYTE      2'h0
`define DWE_SZ_HALF      2'h1
`define DWE_SZ_WORD      2'h2
`define DWE_HSIZE_WORD   3'h2
`define DWE_HTRANS_IDLE  2'h0
`define DWE_HTRANS_NSEQ  2'h2
`define DWE_RSVD_LO      32'h3000_0000
`define DWE_RSVD_HI      32'h3FFF_FFFF

`endif

// >>> shared/dwe_pkg.sv
/*
  Types shared by the DMA engine, its memory model and the test bench.
  Assumes nothing of its surroundings.
*/
package dwe_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_RADDR = 5'b00010,
    ST_RDATA = 5'b00100,
    ST_WADDR = 5'b01000,
    ST_WDATA = 5'b10000
  } dwe_state_e;

  typedef struct packed {
    logic       sel_adc;
    logic [1:0] dst_size;
    logic [1:0] src_size;
    logic       te_ie;
    logic       ht_ie;
    logic       tc_ie;
    logic       en;
  } dwe_ch_cfg_s;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } dwe_ahb_m_s;

endpackage

// >>> test/dma_width_error_irq_test.sv
/*
  Self-checking bench of the DMA block with a memory model.
  Assumes the block is the only master and slave on both buses.
*/
`timescale 1ns/1ps
`include "dwe_cfg.svh"

module dma_width_error_irq_test;
  import dwe_pkg::*;
  logic        clk, rst, hsel, hwrite, hready, hresp, slow;
  logic        m_rdy, m_resp, adc_req, irq, rpend, wpend;
  logic [31:0] haddr, hwdata, hrdata, m_rdata, wa, seed;
  logic [1:0]  htrans;
  logic [2:0]  hsize, wsz;
  logic [7:0]  preq, ack;
  dwe_ahb_m_s  m_ahb;
  logic [32:0] rq[$];
  logic [66:0] wq[$];
  int          error_cnt, n_tests;
  localparam logic [31:0] BA = `DWE_BASE_ADDR;

  dwe_dma i_dut (.sys_clk_i(clk), .rst_i(rst), .s_hsel_i(hsel),
    .s_haddr_i(haddr), .s_htrans_i(htrans), .s_hwrite_i(hwrite),
    .s_hsize_i(hsize), .s_hwdata_i(hwdata), .s_hready_i(hready),
    .s_hrdata_o(hrdata), .s_hready_o(hready), .s_hresp_o(hresp),
    .m_ahb_o(m_ahb), .m_hrdata_i(m_rdata), .m_hready_i(m_rdy),
    .m_hresp_i(m_resp), .periph_req_i(preq), .adc_req_i(adc_req),
    .req_ack_o(ack), .irq_o(irq));
  dwe_mem_model i_mem (.clk_i(clk), .rst_i(rst), .slow_i(slow),
    .m_ahb_i(m_ahb), .hrdata_o(m_rdata), .hready_o(m_rdy),
    .hresp_o(m_resp));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [66:0] seen, input logic [66:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Register access: address phase, then data phase until ready
  task automatic acc(input logic wr, input logic [31:0] a,
                     input logic [2:0] sz, input logic [31:0] d);
    int n;
    @(negedge clk);
    hsel = 1'b1; htrans = 2'h2; hwrite = wr; haddr = a; hsize = sz;
    @(negedge clk);
    hsel = 1'b0; htrans = 2'h0; hwdata = d; n = 0;
    while (hready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    acc(1'b1, a, 3'h2, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back({1'b0, e});
    acc(1'b0, a, 3'h2, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (hready === 1'b1) begin
      if (rpend) check({34'h0, hresp, hrdata}, rq.size() ? {34'h0, rq.pop_front()} : '1);
      rpend = hsel & htrans[1] & !hwrite;
    end
    if (wpend && m_rdy === 1'b1) begin
      check({wa, wsz, m_ahb.hwdata}, wq.size() ? wq.pop_front() : '1);
      wpend = 1'b0;
    end
    if (m_rdy === 1'b1 && m_ahb.htrans[1] && m_ahb.hwrite) begin
      wpend = 1'b1;
      wa = m_ahb.haddr;
      wsz = m_ahb.hsize;
    end
  end

  // Two items on channel c, then flags, interrupt and clearing
  task automatic run(input int c, input logic [1:0] ss, input logic [1:0] ds,
                     input logic [2:0] ie, input logic adc);
    logic [31:0] s, d, cb, it;
    int          k, n;
    cb = BA + 32'h100 + 32'(c * 16);
    seed = xs(seed);
    slow = seed[9];
    s = {24'h20_0000, seed[7:0]} & ~((32'h1 << ss) - 32'h1);
    d = 32'h2000_1000;
    wr(cb + 32'h4, 32'h2);
    wr(cb + 32'h8, s);
    wr(cb + 32'hC, d);
    for (k = 0; k < 2; k++) begin
      it = ({s[31:2], 2'h0} ^ 32'hB3B2_B1B0) >> {s[1:0], 3'h0};
      it = ss == 2'h0 ? {24'h0, it[7:0]} : ss == 2'h1 ? {16'h0, it[15:0]} : it;
      wq.push_back({d, 1'b0, ds, ds == 2'h0 ? {4{it[7:0]}} :
                    ds == 2'h1 ? {2{it[15:0]}} : it});
      s += 32'h1 << ss;
      d += 32'h1 << ds;
    end
    wr(cb, {23'h0, adc, ds, ss, ie, 1'b1});
    if (adc) begin
      preq[c] = 1'b1;
      repeat (10) @(negedge clk);
      preq[c] = 1'b0;
      rd(BA, 32'h0);
    end
    for (k = 0; k < 2; k++) begin
      @(negedge clk);
      if (adc) adc_req = 1'b1;
      else preq[c] = 1'b1;
      n = 0;
      while (ack[c] !== 1'b1 && n < 60) begin
        @(negedge clk);
        n++;
      end
      check(67'(ack[c]), 67'h1);
      preq[c] = 1'b0;
      adc_req = 1'b0;
      if (k == 0) rd(BA, 32'h5 << (4 * c));
    end
    rd(BA, 32'h7 << (4 * c));
    check(67'(irq), 67'(|ie[1:0]));
    wr(BA + 32'h4, 32'h2 << (4 * c));
    rd(BA, 32'h5 << (4 * c));
    check(67'(irq), 67'(ie[1]));
    wr(BA + 32'h4, 32'hF << (4 * c));
    rd(BA, 32'h0);
    check(67'(irq), 67'h0);
    $display("transfer test on channel %0d done", c);
  endtask

  // Faulty transfer: channel drops its enable and flags the error
  task automatic err_run(input int c, input logic [31:0] s,
                         input logic [31:0] d, input logic te);
    logic [31:0] cb;
    cb = BA + 32'h100 + 32'(c * 16);
    wr(cb + 32'h4, 32'h3);
    wr(cb + 32'h8, s);
    wr(cb + 32'hC, d);
    wr(cb, {23'h0, 5'h0A, te, 3'h1});
    preq[c] = 1'b1;
    repeat (12) @(negedge clk);
    preq[c] = 1'b0;
    rd(cb, {23'h0, 5'h0A, te, 3'h0});
    rd(BA, 32'h9 << (4 * c));
    check(67'(irq), 67'(te));
    wr(BA + 32'h4, 32'hF << (4 * c));
    rd(BA, 32'h0);
    check(67'(irq), 67'h0);
    $display("error test on channel %0d done", c);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; haddr = 32'h0;
    hsize = 3'h2; hwdata = 32'h0; preq = 8'h00; adc_req = 1'b0;
    slow = 1'b0; seed = 32'h0000_04C8; rpend = 1'b0; wpend = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rd(BA, 32'h0);
    rd(BA + 32'h4, 32'h0);
    wr(BA, 32'hFFFF_FFFF);
    rd(BA, 32'h0);
    rd(BA + 32'hF0, 32'h0);
    acc(1'b1, BA + 32'h170, 3'h0, 32'hFFFF_FFFF);
    rd(BA + 32'h170, 32'h0);
    rq.push_back({1'b1, 32'h0});
    acc(1'b0, BA, 3'h1, 32'h0);
    $display("register test done");
    run(0, 2'h1, 2'h2, 3'h1, 1'b0);
    run(1, 2'h2, 2'h0, 3'h2, 1'b0);
    run(2, 2'h2, 2'h1, 3'h3, 1'b1);
    run(3, 2'h2, 2'h2, 3'h0, 1'b0);
    run(4, 2'h0, 2'h1, 3'h6, 1'b0);
    err_run(5, 32'h2000_0000, 32'h3000_0100, 1'b1);
    err_run(6, 32'hE000_0000, 32'h2000_2000, 1'b0);
    repeat (4) @(negedge clk);
    check(67'(wq.size() + rq.size()), 67'h0);
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule

// >>> test/dwe_mem_model.sv
/*
  AHB slave memory on the far side of the DMA master port.
  Assumes one master; a read returns a word made from its address.
*/
`timescale 1ns/1ps

module dwe_mem_model (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  input  wire logic           slow_i,
  input  dwe_pkg::dwe_ahb_m_s m_ahb_i,
  output logic [31:0]         hrdata_o,
  output logic                hready_o,
  output logic                hresp_o
);
  import dwe_pkg::*;
  logic        ph_v_ff;
  logic        ph_err_ff;
  logic        err2_ff;
  logic [1:0]  wait_ff;
  logic [31:0] ph_a_ff;
  logic [31:0] word;

  assign word     = {ph_a_ff[31:2], 2'h0} ^ 32'hB3B2_B1B0;
  // Two-cycle error answer for the 0xE region
  assign hresp_o  = ph_v_ff & ph_err_ff & (wait_ff == 2'h0);
  assign hready_o = !ph_v_ff | ((wait_ff == 2'h0) & (!ph_err_ff | err2_ff));
  // Read bus shows no stale value outside a good data phase
  assign hrdata_o = (ph_v_ff & hready_o & !hresp_o) ? word : ~word;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_v_ff   <= 1'b0;
      ph_err_ff <= 1'b0;
      err2_ff   <= 1'b0;
      wait_ff   <= 2'h0;
      ph_a_ff   <= 32'h0000_0000;
    end else if (hready_o) begin
      ph_v_ff   <= m_ahb_i.htrans[1];
      ph_a_ff   <= m_ahb_i.haddr;
      ph_err_ff <= m_ahb_i.haddr[31:28] == 4'hE;
      wait_ff   <= slow_i ? 2'h2 : 2'h0;
      err2_ff   <= 1'b0;
    end else if (wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
    end else begin
      err2_ff <= 1'b1;
    end
  end
endmodule
